// file: logic/dmc_pkg.sv
/*
  constants, register map and carrier types of the mode-control register bank.
  assumes a single 50 MHz system clock and the 16-bit serial control word.
*/
package dmc_pkg;

  localparam int WORD_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam int DATA_BITS = 8;
  localparam int CNT_BITS = 5;

  localparam logic [6:0] ADDR_OUT_FILT = 7'h13;
  localparam logic [6:0] ADDR_MODE = 7'h14;
  localparam logic [6:0] ADDR_ZERO_EN = 7'h15;
  localparam logic [6:0] ADDR_ZERO_STAT = 7'h16;
  localparam logic [6:0] ADDR_PART = 7'h17;

  localparam logic [7:0] RST_OUT_FILT = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_ZERO_EN = 8'h01;
  localparam logic [7:0] RST_ZERO_STAT = 8'h00;

  localparam logic [7:0] MASK_OUT_FILT = 8'hFF;
  localparam logic [7:0] MASK_MODE = 8'h3F;
  localparam logic [7:0] MASK_ZERO_EN = 8'h07;

  localparam int OF_PHASE_REV = 7;
  localparam int OF_ATTEN_RATE = 5;
  localparam int OF_OUT_DIS = 4;
  localparam int OF_RB_EN = 3;
  localparam int OF_STEREO_SEL = 2;
  localparam int OF_ROLLOFF = 1;
  localparam int OF_INZ_MUTE = 0;

  localparam int MD_SOFT_SYSTEM_RESET = 6;
  localparam int MD_DSD = 5;
  localparam int MD_FTHRU = 4;
  localparam int MD_MONO = 3;
  localparam int MD_CHSEL = 2;
  localparam int MD_RATE = 0;

  localparam int ZE_PATTERN = 1;
  localparam int ZE_PCM_EN = 0;

  typedef enum logic [1:0] {
    DMC_RATE_64 = 2'b00,
    DMC_RATE_32 = 2'b01,
    DMC_RATE_128 = 2'b10,
    DMC_RATE_RSV = 2'b11
  } dmc_rate_t;

  typedef enum logic [1:0] {
    DMC_ZP_OFF = 2'b00,
    DMC_ZP_EVEN = 2'b01,
    DMC_ZP_H96 = 2'b10,
    DMC_ZP_H96B = 2'b11
  } dmc_zpat_t;

  typedef struct packed {
    logic rw;
    logic [6:0] addr;
    logic [7:0] data;
  } dmc_word_t;

  typedef struct packed {
    logic phase_reverse;
    logic [1:0] atten_rate;
    logic output_disable;
    logic readback_out_enable;
    logic bypass_stereo_select;
    logic rolloff_select;
    logic infinite_zero_mute_en;
    logic dsd_mode;
    logic filter_through_mode;
    logic mono_mode;
    logic mono_channel_pick;
    dmc_rate_t modulator_rate_sel;
    dmc_zpat_t bitstream_zero_pattern_sel;
    logic pcm_zero_flag_en;
  } dmc_cfg_t;

  typedef struct packed {
    logic pcm_zero;
    logic even_pattern;
    logic pattern_96;
  } dmc_zdet_t;

endpackage

// file: logic/dmc_serial_port.sv
/*
  serial control port: shifts in 16-bit control words msb first and shifts out readback data.
  assumes the control clock is sampled by the system clock, each level lasting at least two cycles.
*/
module dmc_serial_port #(
  parameter int DATA_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ctl_select_n_i,
  input wire logic ctl_clk_i,
  input wire logic ctl_data_i,
  input wire logic [7:0] rd_data_i,
  output logic hdr_valid_o,
  output dmc_pkg::dmc_word_t word_o,
  output logic word_valid_o,
  output logic sdo_o
);

  if (DATA_W != dmc_pkg::DATA_BITS) begin : g_chk
    $error("dmc_serial_port serves 8-bit register data only");
  end

  logic sclk_prev_reg;
  logic [15:0] shift_reg;
  logic [4:0] cnt_reg;
  logic [7:0] out_reg;
  logic rise;
  logic fall;

  assign rise = !ctl_select_n_i && ctl_clk_i && !sclk_prev_reg;
  assign fall = !ctl_select_n_i && !ctl_clk_i && sclk_prev_reg;
  assign word_o = shift_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= ctl_clk_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || ctl_select_n_i) begin
      cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      hdr_valid_o <= 1'b0;
      word_valid_o <= 1'b0;
    end else begin
      hdr_valid_o <= rise && (cnt_reg == 5'(dmc_pkg::HDR_BITS - 1));
      word_valid_o <= rise && (cnt_reg == 5'(dmc_pkg::WORD_BITS - 1));
      if (rise) begin
        shift_reg <= {shift_reg[14:0], ctl_data_i};
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  // readback byte is loaded right after the header and shifted out on falling edges
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || ctl_select_n_i) begin
      out_reg <= 8'h00;
      sdo_o <= 1'b0;
    end else if (hdr_valid_o && shift_reg[7]) begin
      out_reg <= rd_data_i; // (R7)
    end else if (fall && cnt_reg >= 5'(dmc_pkg::HDR_BITS) && shift_reg[4'(cnt_reg - 5'h01)]) begin
      // the direction bit sits one place below the bit count as the word shifts up
      sdo_o <= out_reg[7];
      out_reg <= {out_reg[6:0], 1'b0};
    end
  end

endmodule

// file: logic/dmc_zero_flags.sv
/*
  per-channel zero flag generation for pcm, external filter and bitstream modes.
  assumes the detect inputs come from the audio path in the system clock domain.
*/
module dmc_zero_flags (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic dsd_mode_i,
  input wire dmc_pkg::dmc_zpat_t pattern_sel_i,
  input wire logic pcm_enable_i,
  input wire dmc_pkg::dmc_zdet_t left_det_i,
  input wire dmc_pkg::dmc_zdet_t right_det_i,
  output logic left_flag_o,
  output logic right_flag_o
);

  function automatic logic pick(input logic dsd, input dmc_pkg::dmc_zpat_t sel, input logic pcm_en,
                                input dmc_pkg::dmc_zdet_t det);
    logic res;
    res = 1'b0;
    if (dsd) begin
      case (sel)
        dmc_pkg::DMC_ZP_EVEN: res = det.even_pattern; // (R16)
        dmc_pkg::DMC_ZP_H96, dmc_pkg::DMC_ZP_H96B: res = det.pattern_96; // (R16)
        default: res = 1'b0;
      endcase
    end else begin
      res = pcm_en && det.pcm_zero; // (R17)
    end
    return res;
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      left_flag_o <= 1'b0;
      right_flag_o <= 1'b0;
    end else begin
      left_flag_o <= pick(dsd_mode_i, pattern_sel_i, pcm_enable_i, left_det_i);
      right_flag_o <= pick(dsd_mode_i, pattern_sel_i, pcm_enable_i, right_det_i);
    end
  end

endmodule

// file: logic/dmc_mode_regs.sv
/*
  mode-control register bank: output/filter, mode/reset, zero-flag enable, zero status and part code.
  assumes a host on the serial control port and audio-path zero detectors on the system clock.
*/
// How it works
// (R1) output disable set forces both analog outputs to bipolar zero
// (R2) readback enable routes serial readback data onto the left zero pin
// (R3) in bypass mode stereo select picks bitstream inputs, else pcm mono input
// (R4) rolloff select: zero sharp, one slow interpolation filter response
// (R5) zero-mute enable plus zero on both channels holds outputs at bipolar zero
// (R6) zero-detect mute never acts in bitstream mode
// (R7) control word msb zero writes, one reads the addressed register
// (R8) writing one to system reset gives one reset pulse; bit reads zero
// (R9) bitstream mode bit switches audio input from pcm to bitstream
// (R10) filter-through bit bypasses internal filter for an external one
// (R11) mono bit drives both channels balanced from one input channel
// (R12) channel pick acts in mono only: zero left, one right
// (R13) two-bit rate field: 64, 32, 128 times, code three reserved
// (R14) host avoids 128 times above 100 kHz and gives enough system clock
// (R15) in bitstream mode the rate field selects bitstream clock speed
// (R16) in bitstream mode pattern field: off, even pattern, or 96 hex pattern
// (R17) pcm zero-flag enable defaults one and gates flags in pcm and bypass
// (R18) zero status is read-only and mirrors the zero pins, right bit one
// (R19) status registers can only be read; writes to them are dropped
// (R20) part code register shows a five-bit identifier in its low bits
// (R21) reserved bits read zero; reserved rate code keeps the previous rate
module dmc_mode_regs #(
  parameter logic [4:0] PART_CODE = 5'h0A // arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ctl_select_n_i,
  input wire logic ctl_clk_i,
  input wire logic ctl_data_i,
  input wire dmc_pkg::dmc_zdet_t left_det_i,
  input wire dmc_pkg::dmc_zdet_t right_det_i,
  output dmc_pkg::dmc_cfg_t cfg_o,
  output logic force_bipolar_zero_o,
  output logic soft_system_reset_o,
  output logic use_bitstream_inputs_o,
  output logic mono_right_o,
  output dmc_pkg::dmc_rate_t pcm_rate_sel_o,
  output dmc_pkg::dmc_rate_t bitstream_clock_sel_o,
  output logic left_zero_pin_o,
  output logic right_zero_pin_o
);

  if (PART_CODE === 5'bxxxxx) begin : g_chk
    $error("part code must be a defined value");
  end

  logic [7:0] out_filt_reg;
  logic [7:0] mode_reg;
  logic [7:0] zero_en_reg;
  logic [7:0] rd_data;
  logic hdr_valid;
  logic word_valid;
  dmc_pkg::dmc_word_t word;
  logic serial_readback_out;
  logic left_zero_status;
  logic right_zero_status;
  logic wr_en;
  logic force_next;
  logic [7:0] mode_wr;
  logic [6:0] rd_addr;

  dmc_serial_port #(
    .DATA_W(dmc_pkg::DATA_BITS)
  ) u_port (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ctl_select_n_i(ctl_select_n_i),
    .ctl_clk_i(ctl_clk_i),
    .ctl_data_i(ctl_data_i),
    .rd_data_i(rd_data),
    .hdr_valid_o(hdr_valid),
    .word_o(word),
    .word_valid_o(word_valid),
    .sdo_o(serial_readback_out)
  );

  dmc_zero_flags u_zero (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .dsd_mode_i(cfg_o.dsd_mode),
    .pattern_sel_i(cfg_o.bitstream_zero_pattern_sel),
    .pcm_enable_i(cfg_o.pcm_zero_flag_en),
    .left_det_i(left_det_i),
    .right_det_i(right_det_i),
    .left_flag_o(left_zero_status),
    .right_flag_o(right_zero_status)
  );

  // only direction zero writes; status and part code addresses fall through
  assign wr_en = word_valid && !word.rw; // (R7) (R19)

  // reserved rate code keeps the old rate so the modulator never sees it
  always_comb begin
    mode_wr = word.data & dmc_pkg::MASK_MODE; // (R21)
    mode_wr[dmc_pkg::MD_SOFT_SYSTEM_RESET] = 1'b0; // (R8)
    if (word.data[1:0] == dmc_pkg::DMC_RATE_RSV) begin
      mode_wr[1:0] = mode_reg[1:0]; // (R21)
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || soft_system_reset_o) begin
      out_filt_reg <= dmc_pkg::RST_OUT_FILT;
    end else if (wr_en && word.addr == dmc_pkg::ADDR_OUT_FILT) begin
      out_filt_reg <= word.data & dmc_pkg::MASK_OUT_FILT;
    end
  end

  // a reset request drops the rest of the word; the pulse restores defaults anyway
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || soft_system_reset_o) begin
      mode_reg <= dmc_pkg::RST_MODE;
    end else if (wr_en && word.addr == dmc_pkg::ADDR_MODE && !word.data[dmc_pkg::MD_SOFT_SYSTEM_RESET]) begin
      mode_reg <= mode_wr;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || soft_system_reset_o) begin
      zero_en_reg <= dmc_pkg::RST_ZERO_EN; // (R17)
    end else if (wr_en && word.addr == dmc_pkg::ADDR_ZERO_EN) begin
      zero_en_reg <= word.data & dmc_pkg::MASK_ZERO_EN; // (R21)
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      soft_system_reset_o <= 1'b0;
    end else begin
      soft_system_reset_o <= wr_en && word.addr == dmc_pkg::ADDR_MODE && word.data[dmc_pkg::MD_SOFT_SYSTEM_RESET]; // (R8)
    end
  end

  assign cfg_o.phase_reverse = out_filt_reg[dmc_pkg::OF_PHASE_REV];
  assign cfg_o.atten_rate = out_filt_reg[dmc_pkg::OF_ATTEN_RATE +: 2];
  assign cfg_o.output_disable = out_filt_reg[dmc_pkg::OF_OUT_DIS];
  assign cfg_o.readback_out_enable = out_filt_reg[dmc_pkg::OF_RB_EN];
  assign cfg_o.bypass_stereo_select = out_filt_reg[dmc_pkg::OF_STEREO_SEL];
  assign cfg_o.rolloff_select = out_filt_reg[dmc_pkg::OF_ROLLOFF]; // (R4)
  assign cfg_o.infinite_zero_mute_en = out_filt_reg[dmc_pkg::OF_INZ_MUTE];
  assign cfg_o.dsd_mode = mode_reg[dmc_pkg::MD_DSD]; // (R9)
  assign cfg_o.filter_through_mode = mode_reg[dmc_pkg::MD_FTHRU]; // (R10)
  assign cfg_o.mono_mode = mode_reg[dmc_pkg::MD_MONO]; // (R11)
  assign cfg_o.mono_channel_pick = mode_reg[dmc_pkg::MD_CHSEL];
  assign cfg_o.modulator_rate_sel = dmc_pkg::dmc_rate_t'(mode_reg[dmc_pkg::MD_RATE +: 2]); // (R13)
  assign cfg_o.bitstream_zero_pattern_sel = dmc_pkg::dmc_zpat_t'(zero_en_reg[dmc_pkg::ZE_PATTERN +: 2]);
  assign cfg_o.pcm_zero_flag_en = zero_en_reg[dmc_pkg::ZE_PCM_EN];

  // the byte is loaded after eight bits, when the address still sits in the low byte
  assign rd_addr = word.data[6:0];

  // readback mux, reserved bits zero
  always_comb begin
    if (rd_addr == dmc_pkg::ADDR_OUT_FILT) begin
      rd_data = out_filt_reg;
    end else if (rd_addr == dmc_pkg::ADDR_MODE) begin
      rd_data = mode_reg; // (R8)
    end else if (rd_addr == dmc_pkg::ADDR_ZERO_EN) begin
      rd_data = zero_en_reg;
    end else if (rd_addr == dmc_pkg::ADDR_ZERO_STAT) begin
      rd_data = {6'h00, right_zero_status, left_zero_status}; // (R18)
    end else if (rd_addr == dmc_pkg::ADDR_PART) begin
      rd_data = {3'h0, PART_CODE}; // (R20)
    end else begin
      rd_data = 8'h00;
    end
  end

  // zero-detect mute is off in bitstream mode since the detector there is pattern based
  assign force_next = cfg_o.output_disable // (R1)
    || (cfg_o.infinite_zero_mute_en && !cfg_o.dsd_mode // (R5) (R6)
        && left_det_i.pcm_zero && right_det_i.pcm_zero);

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      force_bipolar_zero_o <= 1'b0;
    end else begin
      force_bipolar_zero_o <= force_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      use_bitstream_inputs_o <= 1'b0;
      mono_right_o <= 1'b0;
      pcm_rate_sel_o <= dmc_pkg::DMC_RATE_64;
      bitstream_clock_sel_o <= dmc_pkg::DMC_RATE_64;
    end else begin
      use_bitstream_inputs_o <= cfg_o.dsd_mode
        || (cfg_o.filter_through_mode && cfg_o.bypass_stereo_select); // (R3)
      mono_right_o <= cfg_o.mono_mode && cfg_o.mono_channel_pick; // (R12)
      if (cfg_o.dsd_mode) begin
        bitstream_clock_sel_o <= cfg_o.modulator_rate_sel; // (R15)
      end else begin
        pcm_rate_sel_o <= cfg_o.modulator_rate_sel; // (R13)
      end
    end
  end

  // the status register mirrors the flag levels, the left pin may carry readback instead
  assign left_zero_pin_o = cfg_o.readback_out_enable ? serial_readback_out : left_zero_status; // (R2) (R18)
  assign right_zero_pin_o = right_zero_status; // (R18)

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_out_disable;
    cfg_o.output_disable |=> force_bipolar_zero_o;
  endproperty
  a_out_disable: assert property (p_out_disable) else $error("output disable did not force zero"); // (R1)

  property p_zero_mute;
    cfg_o.infinite_zero_mute_en && !cfg_o.dsd_mode && left_det_i.pcm_zero && right_det_i.pcm_zero
      |=> force_bipolar_zero_o;
  endproperty
  a_zero_mute: assert property (p_zero_mute) else $error("zero mute did not hold outputs"); // (R5)

  property p_no_mute_dsd;
    cfg_o.dsd_mode && !cfg_o.output_disable |=> !force_bipolar_zero_o;
  endproperty
  a_no_mute_dsd: assert property (p_no_mute_dsd) else $error("mute acted in bitstream mode"); // (R6)

  property p_soft_system_reset_pulse;
    wr_en && word.addr == dmc_pkg::ADDR_MODE && word.data[dmc_pkg::MD_SOFT_SYSTEM_RESET]
      |=> soft_system_reset_o ##1 (!soft_system_reset_o && zero_en_reg == dmc_pkg::RST_ZERO_EN
      && mode_reg == dmc_pkg::RST_MODE && out_filt_reg == dmc_pkg::RST_OUT_FILT);
  endproperty
  a_soft_system_reset_pulse: assert property (p_soft_system_reset_pulse) else $error("system reset pulse wrong"); // (R8)

  property p_soft_system_reset_reads_zero;
    hdr_valid && rd_addr == dmc_pkg::ADDR_MODE |-> !rd_data[dmc_pkg::MD_SOFT_SYSTEM_RESET];
  endproperty
  a_soft_system_reset_reads_zero: assert property (p_soft_system_reset_reads_zero) else $error("reset bit read as one"); // (R8)

  property p_status_no_write;
    word_valid && (word.addr == dmc_pkg::ADDR_ZERO_STAT || word.addr == dmc_pkg::ADDR_PART)
      |=> $stable(out_filt_reg) && $stable(mode_reg) && $stable(zero_en_reg);
  endproperty
  a_status_no_write: assert property (p_status_no_write) else $error("status write changed state"); // (R19)

  property p_rsv_rate;
    wr_en && word.addr == dmc_pkg::ADDR_MODE && !word.data[dmc_pkg::MD_SOFT_SYSTEM_RESET] && word.data[1:0] == 2'h3
      |=> mode_reg[1:0] == $past(mode_reg[1:0]) && mode_reg[1:0] != 2'h3;
  endproperty
  a_rsv_rate: assert property (p_rsv_rate) else $error("reserved rate code accepted"); // (R21)

  property p_rate_write;
    wr_en && word.addr == dmc_pkg::ADDR_MODE && !word.data[dmc_pkg::MD_SOFT_SYSTEM_RESET] && word.data[1:0] != 2'h3
      && !cfg_o.dsd_mode |=> ##1 (pcm_rate_sel_o == $past(word.data[1:0], 2) || cfg_o.dsd_mode);
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate select not applied"); // (R13)

  property p_status_read;
    hdr_valid && rd_addr == dmc_pkg::ADDR_ZERO_STAT
      |-> rd_data == {6'h00, right_zero_pin_o, left_zero_status};
  endproperty
  a_status_read: assert property (p_status_read) else $error("zero status mismatch"); // (R18)

  property p_part_read;
    hdr_valid && rd_addr == dmc_pkg::ADDR_PART |-> rd_data == {3'h0, PART_CODE};
  endproperty
  a_part_read: assert property (p_part_read) else $error("part code read wrong"); // (R20)

  property p_readback_pin;
    cfg_o.readback_out_enable && $changed(serial_readback_out) |-> left_zero_pin_o == serial_readback_out;
  endproperty
  a_readback_pin: assert property (p_readback_pin) else $error("readback not on left pin"); // (R2)

  property p_mono_pick;
    !cfg_o.mono_mode |=> !mono_right_o;
  endproperty
  a_mono_pick: assert property (p_mono_pick) else $error("channel pick acted outside mono"); // (R12)

  property p_bypass_mono;
    cfg_o.filter_through_mode && !cfg_o.dsd_mode && !cfg_o.bypass_stereo_select |=> !use_bitstream_inputs_o;
  endproperty
  a_bypass_mono: assert property (p_bypass_mono) else $error("bypass mono took bitstream inputs"); // (R3)

  property p_bypass_stereo;
    cfg_o.filter_through_mode && cfg_o.bypass_stereo_select |=> use_bitstream_inputs_o;
  endproperty
  a_bypass_stereo: assert property (p_bypass_stereo) else $error("bypass stereo missed inputs"); // (R3)

  property p_dsd_inputs;
    cfg_o.dsd_mode |=> use_bitstream_inputs_o;
  endproperty
  a_dsd_inputs: assert property (p_dsd_inputs) else $error("bitstream mode kept pcm input"); // (R9)

  property p_mono_right;
    cfg_o.mono_mode && cfg_o.mono_channel_pick |=> mono_right_o;
  endproperty
  a_mono_right: assert property (p_mono_right) else $error("mono right pick not applied"); // (R11)

  property p_bs_rate;
    cfg_o.dsd_mode |=> bitstream_clock_sel_o == $past(cfg_o.modulator_rate_sel);
  endproperty
  a_bs_rate: assert property (p_bs_rate) else $error("bitstream clock select not applied"); // (R15)

  property p_pcm_rate_hold;
    cfg_o.dsd_mode |=> $stable(pcm_rate_sel_o);
  endproperty
  a_pcm_rate_hold: assert property (p_pcm_rate_hold) else $error("pcm rate moved in bitstream mode"); // (R15)

  property p_rsv_bits;
    mode_reg[7:6] == 2'h0 && zero_en_reg[7:3] == 5'h00;
  endproperty
  a_rsv_bits: assert property (p_rsv_bits) else $error("reserved bits stored"); // (R21)

  property p_pcm_flag;
    !cfg_o.dsd_mode && cfg_o.pcm_zero_flag_en |=> right_zero_pin_o == $past(right_det_i.pcm_zero);
  endproperty
  a_pcm_flag: assert property (p_pcm_flag) else $error("pcm zero flag wrong"); // (R17)

  property p_dsd_flag_off;
    cfg_o.dsd_mode && cfg_o.bitstream_zero_pattern_sel == dmc_pkg::DMC_ZP_OFF |=> !right_zero_pin_o;
  endproperty
  a_dsd_flag_off: assert property (p_dsd_flag_off) else $error("disabled bitstream flag set"); // (R16)

  property p_even_flag;
    cfg_o.dsd_mode && cfg_o.bitstream_zero_pattern_sel == dmc_pkg::DMC_ZP_EVEN
      |=> right_zero_pin_o == $past(right_det_i.even_pattern);
  endproperty
  a_even_flag: assert property (p_even_flag) else $error("even pattern flag wrong"); // (R16)

  property p_h96_flag;
    cfg_o.dsd_mode && cfg_o.bitstream_zero_pattern_sel[1] |=> right_zero_pin_o == $past(right_det_i.pattern_96);
  endproperty
  a_h96_flag: assert property (p_h96_flag) else $error("96 pattern flag wrong"); // (R16)

  property p_zero_en_write;
    wr_en && word.addr == dmc_pkg::ADDR_ZERO_EN |=> zero_en_reg == ($past(word.data) & dmc_pkg::MASK_ZERO_EN);
  endproperty
  a_zero_en_write: assert property (p_zero_en_write) else $error("zero enable write lost"); // (R7)

  property p_read_no_write;
    word_valid && word.rw |=> $stable(out_filt_reg) && $stable(mode_reg) && $stable(zero_en_reg);
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("read changed a register"); // (R7)

  c_soft_system_reset: cover property (soft_system_reset_o);
  c_read: cover property (hdr_valid && word.data[7] ##[1:300] word_valid);
  c_dsd_disable: cover property (cfg_o.dsd_mode && cfg_o.output_disable ##1 force_bipolar_zero_o);
  c_zero_mute: cover property (!cfg_o.output_disable && force_bipolar_zero_o);

endmodule

// file: bench/dmc_host_model.sv
/*
  host controller model for the serial control port: sends 16-bit control words and collects readback bits.
  assumes the device routes readback onto the sensed pin whenever a read result is wanted.
*/
module dmc_host_model (
  input wire logic sys_clk_i,
  input wire logic readback_i,
  output logic ctl_select_n_o,
  output logic ctl_clk_o,
  output logic ctl_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ctl_select_n_o = 1'b1;
    ctl_clk_o = 1'b0;
    ctl_data_o = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // direction bit leads, then address and data, msb first
  // no sample rate exists here, so a 128x choice never meets a fast rate
  task automatic xfer(input logic [15:0] word, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge sys_clk_i);
    ctl_select_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ctl_data_o = word[i];
      hold(4);
      ctl_clk_o = 1'b1;
      hold(4);
      if (i < 8) begin
        rd[i] = readback_i;
      end
      ctl_clk_o = 1'b0;
    end
    hold(4);
    ctl_select_n_o = 1'b1;
    // a released data line must not keep looking valid
    ctl_data_o = ~ctl_data_o;
    hold(4);
  endtask
endmodule

// file: bench/test_dmc_mode_regs.sv
/*
  self-checking bench for the mode-control register bank, driving the serial port through the host model.
  assumes a 50 MHz clock and that inputs change on the falling edge only.
*/
module test_dmc_mode_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] PART = 5'h15; // arbitrary value

  logic sys_clk = 1'b0;
  logic reset_n;
  logic sel_n, sclk, sdata;
  dmc_pkg::dmc_zdet_t ldet, rdet;
  dmc_pkg::dmc_cfg_t cfg;
  logic force_bpz, soft_system_reset_pulse, use_bs, mono_r, lpin, rpin;
  dmc_pkg::dmc_rate_t pcm_rate, bs_rate, pcm_exp, bs_exp;
  int err_total, tests_run, pulse_cnt;
  logic [7:0] m13, m14, m15, rd, w13, w14;

  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (soft_system_reset_pulse === 1'b1) begin
      pulse_cnt++;
    end
  end

  dmc_mode_regs #(.PART_CODE(PART)) dmc_mode_regs_inst (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .ctl_select_n_i(sel_n), .ctl_clk_i(sclk),
    .ctl_data_i(sdata), .left_det_i(ldet), .right_det_i(rdet), .cfg_o(cfg),
    .force_bipolar_zero_o(force_bpz), .soft_system_reset_o(soft_system_reset_pulse), .use_bitstream_inputs_o(use_bs),
    .mono_right_o(mono_r), .pcm_rate_sel_o(pcm_rate), .bitstream_clock_sel_o(bs_rate),
    .left_zero_pin_o(lpin), .right_zero_pin_o(rpin)
  );

  dmc_host_model dmc_host_model_inst (
    .sys_clk_i(sys_clk), .readback_i(lpin), .ctl_select_n_o(sel_n), .ctl_clk_o(sclk), .ctl_data_o(sdata)
  );

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    dmc_host_model_inst.xfer({1'b0, a, d}, rd);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    dmc_host_model_inst.xfer({1'b1, a, 8'h00}, rd);
    check(32'(rd), 32'(exp));
  endtask

  // zero flag as seen on a pin: pattern select in bitstream mode, pcm enable otherwise
  function automatic logic flag_exp(dmc_pkg::dmc_zdet_t d);
    if (m14[5]) begin
      return (m15[2:1] == 2'b00) ? 1'b0 : (m15[2] ? d.pattern_96 : d.even_pattern);
    end
    return m15[0] & d.pcm_zero;
  endfunction

  task automatic apply(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    wr(7'h13, a);
    wr(7'h14, b);
    wr(7'h15, c);
    m13 = a & dmc_pkg::MASK_OUT_FILT;
    m14 = b & dmc_pkg::MASK_MODE;
    m15 = c & dmc_pkg::MASK_ZERO_EN;
    if (m14[5]) begin
      bs_exp = dmc_pkg::dmc_rate_t'(m14[1:0]);
    end else begin
      pcm_exp = dmc_pkg::dmc_rate_t'(m14[1:0]);
    end
  endtask

  task automatic chk_state();
    check(32'(cfg), 32'({m13, m14[5:0], m15[2:0]}));
    check(32'(force_bpz), 32'(m13[4] | (m13[0] & ldet.pcm_zero & rdet.pcm_zero & ~m14[5])));
    check(32'(use_bs), 32'(m14[5] | (m14[4] & m13[2])));
    check(32'(mono_r), 32'(m14[3] & m14[2]));
    check(32'(pcm_rate), 32'(pcm_exp));
    check(32'(bs_rate), 32'(bs_exp));
    check(32'(rpin), 32'(flag_exp(rdet)));
    check(32'(lpin), 32'(m13[3] ? 1'b0 : flag_exp(ldet)));
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    pulse_cnt = 0;
    reset_n = 1'b0;
    ldet = '0;
    rdet = '0;
    m13 = dmc_pkg::RST_OUT_FILT;
    m14 = dmc_pkg::RST_MODE;
    m15 = dmc_pkg::RST_ZERO_EN;
    pcm_exp = dmc_pkg::DMC_RATE_64;
    bs_exp = dmc_pkg::DMC_RATE_64;
    void'($urandom(32'h41CC5214));
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk_state();
    // random settings with readback enabled, read back through the serial port
    for (int n = 0; n < 10; n++) begin
      ldet = dmc_pkg::dmc_zdet_t'($urandom);
      rdet = dmc_pkg::dmc_zdet_t'($urandom);
      w13 = 8'($urandom) | 8'h08;
      w14 = 8'($urandom) & 8'hBF;
      if (w14[1:0] == 2'b11) begin
        w14[1:0] = 2'b10;
      end
      apply(w13, w14, 8'($urandom));
      chk_state();
      rd_chk(7'h13, m13);
      rd_chk(7'h14, m14);
      rd_chk(7'h15, m15);
      rd_chk(7'h16, {6'h00, flag_exp(rdet), flag_exp(ldet)});
    end
    // rate codes 0 to 2 in pcm mode and in bitstream mode, then the reserved code in pcm mode
    for (int c = 0; c < 6; c++) begin
      apply(8'h00, {2'b00, c > 2, 3'b000, 2'(c % 3)}, 8'h01);
      chk_state();
    end
    apply(8'h00, 8'h01, 8'h01);
    wr(7'h14, 8'h03);
    check(32'(pcm_rate), 32'(pcm_exp));
    // every flag mode with zero-detect mute on and both channels at zero
    for (int c = 0; c < 8; c++) begin
      ldet = dmc_pkg::dmc_zdet_t'($urandom) | 3'b100;
      rdet = dmc_pkg::dmc_zdet_t'($urandom) | 3'b100;
      apply(8'h01, {2'b00, c[2], 5'b00000}, {5'b00000, c[1:0], c[2] ^ c[0]});
      chk_state();
    end
    // read-only and unmapped places
    apply(8'h08, 8'h00, 8'h01);
    wr(7'h16, 8'hFF);
    wr(7'h17, 8'hFF);
    wr(7'h10, 8'h5A);
    chk_state();
    rd_chk(7'h17, {3'b000, PART});
    rd_chk(7'h10, 8'h00);
    // software reset gives one pulse and returns the defaults
    apply(8'hFF, 8'h3E, 8'h06);
    pulse_cnt = 0;
    wr(7'h14, 8'h7F);
    check(32'(pulse_cnt), 32'd1);
    m13 = dmc_pkg::RST_OUT_FILT;
    m14 = dmc_pkg::RST_MODE;
    m15 = dmc_pkg::RST_ZERO_EN;
    check(32'(cfg), 32'({m13, m14[5:0], m15[2:0]}));
    finish_test();
  end
endmodule
